// [bus_events_consts.vh]
// constants for the bus line filter, bus event flags and range matching
// assumes a 32-bit avalon-mm slave with word-aligned registers
`ifndef BUS_EVENTS_CONSTS_VH
`define BUS_EVENTS_CONSTS_VH

// ----------------------------------------------------------------
// register indices (word address = index)
// ----------------------------------------------------------------
`define IDX_FILTER_EVENTS 4'h6
`define IDX_RANGE_LIMIT 4'h7
`define IDX_CONTROL 4'h8
`define IDX_STATUS 4'h9
`define IDX_IRQ_MASK 4'hA
`define IDX_PRIMARY_ADDR 4'hB
`define IDX_MATCH 4'hC

// ----------------------------------------------------------------
// filter and events register fields
// ----------------------------------------------------------------
`define BIT_STOP_HOLDOFF 7
`define BIT_STOP_FLAG 6
`define BIT_SS_IRQ_EN 5
`define BIT_START_FLAG 4
`define FILTER_MSB 3
`define FILTER_RESET 8'h00

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define BIT_MOD_ENABLE 0
`define BIT_MOD_IRQ_EN 1
`define BIT_RANGE_EN 2

// ----------------------------------------------------------------
// status (w1c) / mask register fields
// ----------------------------------------------------------------
`define BIT_MOD_IRQ_FLAG 0
`define BIT_XFER_DONE 1
`define BIT_RANGE_HIT 2

// ----------------------------------------------------------------
// other widths and timing
// ----------------------------------------------------------------
`define BITS_PER_BYTE 4'h9
`define RANGE_RESET 8'h00

`endif

// [line_glitch_filter.v]
// glitch filter for one bus line
// assumes the input is already synchronised to mclk
`timescale 1ns/1ps
`include "bus_events_consts.vh"

module line_glitch_filter (
  // clock and reset
  input wire mclk,
  input wire rstn,
  // control
  input wire [3:0] width,
  // line in and filtered line out
  input wire line_in,
  output reg line_out
);

  reg [3:0] stable_q; // cycles the new level has held

  // ----------------------------------------------------------------
  // pass a level once held longer than width
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stable_q <= 4'h0;
      line_out <= 1'b1;
    end else if (width == 4'h0) begin
      // bypass
      stable_q <= 4'h0;
      line_out <= line_in;
    end else if (line_in == line_out) begin
      stable_q <= 4'h0; // glitch ended, restart count
    end else if (stable_q >= width) begin
      line_out <= line_in;
      stable_q <= 4'h0;
    end else begin
      stable_q <= stable_q + 4'h1;
    end
  end

endmodule

// [bus_events_top.v]
// bus line filter, start/stop events, stop holdoff and range matching
// assumes scl/sda pins asynchronous; avalon-mm master on mclk
// What this block does
// - holdoff enable delays stop while transferring
// - finish byte in flight, then acknowledge stop
// - idle or disabled: acknowledge stop at once
// - holdoff clear: stop never gated
// - raise transfer-complete interrupt after wake
// - stop condition sets sticky stop flag
// - start condition sets sticky start flag
// - start/stop enable gates the start/stop part of module interrupt; wake sets it regardless
// - module flag re-asserts while event flag set
// - filter blocks pulses up to n; 0 bypass
// - range field holds 7-bit upper limit
// - nonzero limit write activates range register when range match enabled
// - range bit 0 reads zero
// - match above primary, up to range
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "bus_events_consts.vh"

module bus_events_top (
  // clock and reset
  input wire mclk,
  input wire rstn,
  // avalon-mm slave
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output reg waitrequest,
  // bus pins (inputs only; this block observes)
  input wire scl_in,
  input wire sda_in,
  // power controller handshake
  input wire stop_req,
  output reg stop_ack,
  // interrupt
  output reg irq
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg [1:0] scl_sync_q; // bit 0 read only by bit 1
  reg [1:0] sda_sync_q;
  reg stop_sync0_q;
  reg stop_sync1_q;

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      scl_sync_q <= 2'b11;
      sda_sync_q <= 2'b11;
      stop_sync0_q <= 1'b0;
      stop_sync1_q <= 1'b0;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      stop_sync0_q <= stop_req;
      stop_sync1_q <= stop_sync0_q;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg holdoff_en_q; // stop_holdoff_enable
  reg ss_irq_en_q; // start_stop_irq_enable
  reg [3:0] filt_q; // glitch_filter_width
  reg start_flag_q; // bus_start_flag
  reg stop_flag_q; // bus_stop_flag
  reg [6:0] range_q; // range_upper_address
  reg range_active_q; // range register armed
  reg mod_en_q; // module enable
  reg mod_irq_en_q; // module_irq_enable
  reg range_en_q; // range_match_enable
  reg [6:0] primary_q; // primary_slave_address
  reg [2:0] status_q; // irq flag, transfer done, range hit
  reg [2:0] mask_q;
  reg [6:0] last_addr_q; // last received address
  reg hit_q; // address byte matched range (one-cycle pulse)

  // ----------------------------------------------------------------
  // glitch filters, one per line
  // ----------------------------------------------------------------
  wire scl_f;
  wire sda_f;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_filt
      wire f_out;
      line_glitch_filter u_filt (
        .mclk(mclk),
        .rstn(rstn),
        .width(filt_q),
        .line_in(gi == 0 ? scl_sync_q[1] : sda_sync_q[1]),
        .line_out(f_out)
      );
    end
  endgenerate
  assign scl_f = g_filt[0].f_out;
  assign sda_f = g_filt[1].f_out;

  // ----------------------------------------------------------------
  // start / stop detection and byte tracking
  // ----------------------------------------------------------------
  reg scl_d1_q;
  reg sda_d1_q;
  reg busy_q; // between start and stop
  reg [3:0] bitcnt_q; // scl rises within current byte (incl ack)
  reg [7:0] shift_q;
  reg first_byte_q;

  wire start_ev = scl_f & scl_d1_q & sda_d1_q & ~sda_f;
  wire stop_ev = scl_f & scl_d1_q & ~sda_d1_q & sda_f;
  wire scl_rise = scl_f & ~scl_d1_q;
  wire byte_end = scl_rise && (bitcnt_q == `BITS_PER_BYTE - 4'h1);

  // range match of a 7-bit address
  function in_range;
    input [6:0] a;
    input [6:0] lo;
    input [6:0] hi;
    begin
      in_range = (a > lo) && (a <= hi);
    end
  endfunction

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
      busy_q <= 1'b0;
      bitcnt_q <= 4'h0;
      shift_q <= 8'h00;
      first_byte_q <= 1'b0;
      last_addr_q <= 7'h00;
      hit_q <= 1'b0;
    end else begin
      scl_d1_q <= scl_f;
      sda_d1_q <= sda_f;
      hit_q <= 1'b0;
      if (start_ev) begin
        busy_q <= mod_en_q;
        bitcnt_q <= 4'h0;
        first_byte_q <= 1'b1;
      end else if (stop_ev) begin
        busy_q <= 1'b0;
        bitcnt_q <= 4'h0;
      end else if (scl_rise && busy_q) begin
        if (byte_end) begin
          bitcnt_q <= 4'h0;
          first_byte_q <= 1'b0;
          if (first_byte_q) begin
            last_addr_q <= shift_q[7:1];
            hit_q <= range_en_q && range_active_q &&
                     in_range(shift_q[7:1], primary_q, range_q);
          end
        end else begin
          bitcnt_q <= bitcnt_q + 4'h1;
          shift_q <= {shift_q[6:0], sda_f};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // stop-mode holdoff handshake
  // ----------------------------------------------------------------
  reg stop_pend_q; // request waiting on a byte boundary
  reg wake_irq_q; // raise transfer done after wake

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stop_ack <= 1'b0;
      stop_pend_q <= 1'b0;
      wake_irq_q <= 1'b0;
    end else if (!stop_sync1_q) begin
      stop_ack <= 1'b0;
      stop_pend_q <= 1'b0;
      wake_irq_q <= 1'b0;
    end else if (!holdoff_en_q) begin
      stop_ack <= 1'b1;
      wake_irq_q <= mod_irq_en_q;
    end else if (!busy_q || !mod_en_q) begin
      stop_ack <= 1'b1;
      wake_irq_q <= mod_irq_en_q;
    end else if (!stop_ack) begin
      stop_pend_q <= 1'b1;
      if (byte_end) begin
        stop_ack <= 1'b1;
        wake_irq_q <= mod_irq_en_q;
      end
    end
  end

  // wake seen as release of the stop request after acknowledge
  wire wake_ev = stop_ack & ~stop_sync1_q & wake_irq_q;

  // ----------------------------------------------------------------
  // avalon-mm slave, one wait cycle per access
  // ----------------------------------------------------------------
  wire req = read | write;
  wire rd_load = read & waitrequest; // load data as waitrequest drops
  wire wr = write & ~waitrequest;
  wire [7:0] wb = writedata[7:0];
  wire wr_flt = wr && (address == `IDX_FILTER_EVENTS);
  wire wr_st = wr && (address == `IDX_STATUS);

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= ~(req & waitrequest);
    end
  end

  // ----------------------------------------------------------------
  // register writes and sticky flags (set beats clear)
  // ----------------------------------------------------------------
  wire ev_pending = start_flag_q | stop_flag_q;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      holdoff_en_q <= 1'b0;
      ss_irq_en_q <= 1'b0;
      filt_q <= 4'h0;
      start_flag_q <= 1'b0;
      stop_flag_q <= 1'b0;
      range_q <= 7'h00;
      range_active_q <= 1'b0;
      mod_en_q <= 1'b0;
      mod_irq_en_q <= 1'b0;
      range_en_q <= 1'b0;
      primary_q <= 7'h00;
      mask_q <= 3'b000;
      status_q <= 3'b000;
    end else begin
      if (wr_flt) begin
        holdoff_en_q <= wb[`BIT_STOP_HOLDOFF];
        ss_irq_en_q <= wb[`BIT_SS_IRQ_EN];
        filt_q <= wb[`FILTER_MSB:0];
      end
      if (start_ev) begin
        start_flag_q <= 1'b1;
      end else if (wr_flt && wb[`BIT_START_FLAG]) begin
        start_flag_q <= 1'b0;
      end
      if (stop_ev) begin
        stop_flag_q <= 1'b1;
      end else if (wr_flt && wb[`BIT_STOP_FLAG]) begin
        stop_flag_q <= 1'b0;
      end
      if (wr && address == `IDX_RANGE_LIMIT) begin
        range_q <= wb[7:1];
        if (range_en_q && wb[7:1] != 7'h00) begin
          range_active_q <= 1'b1;
        end
      end
      if (wr && address == `IDX_CONTROL) begin
        mod_en_q <= wb[`BIT_MOD_ENABLE];
        mod_irq_en_q <= wb[`BIT_MOD_IRQ_EN];
        range_en_q <= wb[`BIT_RANGE_EN];
      end
      if (wr && address == `IDX_PRIMARY_ADDR) begin
        primary_q <= wb[6:0];
      end
      if (wr && address == `IDX_IRQ_MASK) begin
        mask_q <= wb[2:0];
      end
      // module irq flag: start/stop flag pending while enabled, or wake
      if ((ss_irq_en_q && ev_pending) || wake_ev) begin
        status_q[`BIT_MOD_IRQ_FLAG] <= 1'b1;
      end else if (wr_st && wb[`BIT_MOD_IRQ_FLAG]) begin
        status_q[`BIT_MOD_IRQ_FLAG] <= 1'b0;
      end
      if (wake_ev || byte_end) begin
        status_q[`BIT_XFER_DONE] <= 1'b1;
      end else if (wr_st && wb[`BIT_XFER_DONE]) begin
        status_q[`BIT_XFER_DONE] <= 1'b0;
      end
      if (hit_q) begin
        status_q[`BIT_RANGE_HIT] <= 1'b1;
      end else if (wr_st && wb[`BIT_RANGE_HIT]) begin
        status_q[`BIT_RANGE_HIT] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux and interrupt output
  // ----------------------------------------------------------------
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h0000_0000;
    case (address)
      `IDX_FILTER_EVENTS: rd_d[7:0] = {holdoff_en_q, stop_flag_q,
        ss_irq_en_q, start_flag_q, filt_q};
      `IDX_RANGE_LIMIT: rd_d[7:0] = {range_q, 1'b0};
      `IDX_CONTROL: rd_d[2:0] = {range_en_q, mod_irq_en_q, mod_en_q};
      `IDX_STATUS: rd_d[2:0] = status_q;
      `IDX_IRQ_MASK: rd_d[2:0] = mask_q;
      `IDX_PRIMARY_ADDR: rd_d[6:0] = primary_q;
      `IDX_MATCH: rd_d[9:0] = {busy_q, range_active_q, 1'b0, last_addr_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      readdata <= 32'h0000_0000;
      irq <= 1'b0;
    end else begin
      if (rd_load) begin
        readdata <= rd_d;
      end
      irq <= |(status_q & mask_q);
    end
  end

endmodule

// [bus_events_checker.sv]
// checker for the register bus and stop handshake of bus_events_top
// assumes it is bound to bus_events_top and sees only its ports
`timescale 1ns/1ps
module bus_events_checker (
  // clock and reset
  input wire mclk,
  input wire rstn,
  // register bus
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [31:0] readdata,
  input wire waitrequest,
  // power handshake
  input wire stop_req,
  input wire stop_ack
);
  reg hold_q; // copy of the holdoff bit
  // ----------------------------------------
  // holdoff copy taken from accepted writes
  // ----------------------------------------
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hold_q <= 1'b0;
    end else if (write && !waitrequest && address == 4'h6) begin
      hold_q <= writedata[7];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  wait_one_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("wait state longer than one cycle");
  wait_high_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low two cycles");
  high_zero_a: assert property (read && !waitrequest && address != 4'hC |->
    readdata[31:8] == 0)
    else $error("upper read bits not zero");
  range_bit0_a: assert property (read && !waitrequest &&
    address == 4'h7 |-> !readdata[0])
    else $error("range bit 0 read as one");
  read_hold_a: assert property ($changed(readdata) |-> read && !waitrequest)
    else $error("read data changed outside a read");
  ack_fast_a: assert property (!hold_q && $rose(stop_req) |->
    ##[1:8] stop_ack)
    else $error("stop ack late without holdoff");
  ack_drop_a: assert property ($fell(stop_req) |-> ##[1:8] !stop_ack)
    else $error("stop ack stuck");
  ack_none_a: assert property (!stop_req [*6] |-> !stop_ack)
    else $error("stop ack without request");
endmodule
bind bus_events_top bus_events_checker chk_i (.mclk(mclk), .rstn(rstn),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .stop_req(stop_req),
  .stop_ack(stop_ack));

// [i2c_far_master.sv]
// far-side bus master driving the two bus lines
// assumes pull-ups: a released line reads high; link period 160 ns
`timescale 1ns/1ps
module i2c_far_master (
  // bus lines
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // start: data falls while clock high, then clock low
  task start_c;
    sda = 1'b0;
    #80 scl = 1'b0;
  endtask
  // eight bits msb first, ninth slot released high
  task put_byte(input logic [7:0] b);
    for (int i = 8; i >= 0; i--) begin
      sda = (i > 0) ? b[i-1] : 1'b1;
      #40 scl = 1'b1;
      #80 scl = 1'b0;
      #40;
    end
  endtask
  // stop: data rises while clock high
  task stop_c;
    sda = 1'b0;
    #40 scl = 1'b1;
    #40 sda = 1'b1;
    #80;
  endtask
  // low pulse on data with clock idle high
  task glitch(input int w);
    sda = 1'b0;
    #(w * 20) sda = 1'b1;
    #600;
  endtask
endmodule

// [test_i2c_filter_events_range_match.sv]
// testbench for bus_events_top with a far-side bus master
// assumes 50 MHz mclk and word-indexed registers
`timescale 1ns/1ps
module test_i2c_filter_events_range_match;
  logic mclk, rstn, read, write, stop_req;
  logic [3:0] address;
  logic [31:0] writedata;
  wire [31:0] readdata;
  wire waitrequest, stop_ack, irq, scl, sda;
  logic [15:0] exp_q[$]; // mask and value per read
  logic [15:0] ev;
  logic [6:0] hi, a;
  int err_total, checks_done;
  int flt_n[5] = '{5, 5, 15, 15, 0};
  int flt_w[5] = '{4, 8, 13, 18, 2};
  bus_events_top dut (.mclk(mclk), .rstn(rstn), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .scl_in(scl), .sda_in(sda),
    .stop_req(stop_req), .stop_ack(stop_ack), .irq(irq));
  i2c_far_master pm (.scl(scl), .sda(sda));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  // one bus access, held until waitrequest is sampled low
  task acc(input logic w, input logic [3:0] ad, input logic [7:0] d);
    @(posedge mclk);
    write <= w;
    read <= !w;
    address <= ad;
    writedata <= {24'h0, d};
    do @(posedge mclk); while (waitrequest !== 1'b0);
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task wr(input logic [3:0] ad, input logic [7:0] d);
    acc(1'b1, ad, d);
  endtask
  task rd(input logic [3:0] ad, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back({m, e});
    acc(1'b0, ad, 8'h00);
  endtask
  // compare each finished read with the oldest note
  always @(posedge mclk) begin
    if (read && waitrequest === 1'b0) begin
      ev = exp_q.pop_front();
      chk((readdata[7:0] & ev[15:8]) === ev[7:0], "read data");
    end
  end
  task print_verdict;
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    err_total++;
    print_verdict;
  end
  initial begin
    {rstn, read, write, stop_req, address, writedata} = 0;
    void'($urandom(32'h74bf));
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    rd(4'h6, 8'h00, 8'hff);
    rd(4'h7, 8'h00, 8'hff);
    wr(4'h3, 8'h5a);
    rd(4'h3, 8'h00, 8'hff);
    // start and stop flags with their interrupt
    wr(4'h8, 8'h01);
    wr(4'hA, 8'h01);
    wr(4'h6, 8'h20);
    pm.start_c();
    pm.stop_c();
    rd(4'h6, 8'h70, 8'hff);
    repeat (2) @(posedge mclk);
    chk(irq === 1'b1, "event irq");
    wr(4'h9, 8'h01);
    repeat (4) @(posedge mclk);
    chk(irq === 1'b1, "flag set again");
    wr(4'h6, 8'h70);
    wr(4'h9, 8'h01);
    repeat (4) @(posedge mclk);
    chk(irq === 1'b0, "irq cleared");
    // filter widths either side of the limit, then bypass
    for (int i = 0; i < 5; i++) begin
      wr(4'h6, 8'(flt_n[i]));
      pm.glitch(flt_w[i]);
      rd(4'h6, 8'(flt_n[i]) | (flt_w[i] > flt_n[i] ? 8'h50 : 8'h00),
        8'hff);
      wr(4'h6, 8'(flt_n[i]) | 8'h50);
    end
    chk(irq === 1'b0, "events masked");
    // range upper limit, read-only bit 0, hit and miss
    hi = 7'($urandom_range(8'h7e, 8'h12));
    a = 7'($urandom_range(32'(hi), 8'h11));
    wr(4'h8, 8'h05);
    wr(4'hB, 8'h10);
    wr(4'h7, {hi, 1'b1});
    rd(4'h7, {hi, 1'b0}, 8'hff);
    pm.start_c();
    pm.put_byte({a, 1'b0});
    pm.stop_c();
    rd(4'h9, 8'h04, 8'h04);
    rd(4'hC, {1'b0, a}, 8'hff);
    wr(4'h9, 8'h04);
    pm.start_c();
    pm.put_byte({hi + 7'h01, 1'b0});
    pm.stop_c();
    rd(4'h9, 8'h00, 8'h04);
    // holdoff while busy, then wake
    wr(4'h8, 8'h03);
    wr(4'h9, 8'h07);
    wr(4'h6, 8'h80);
    pm.start_c();
    fork
      pm.put_byte(8'ha4);
      begin
        #400 @(posedge mclk);
        stop_req <= 1'b1;
        #600 chk(stop_ack === 1'b0, "ack early");
      end
    join
    repeat (8) @(posedge mclk);
    chk(stop_ack === 1'b1, "ack after byte");
    wr(4'h9, 8'h07);
    stop_req <= 1'b0;
    repeat (8) @(posedge mclk);
    rd(4'h9, 8'h03, 8'h03);
    pm.stop_c();
    // holdoff while idle, then holdoff clear while busy
    stop_req <= 1'b1;
    repeat (8) @(posedge mclk);
    chk(stop_ack === 1'b1, "idle ack");
    stop_req <= 1'b0;
    wr(4'h6, 8'h00);
    pm.start_c();
    fork
      pm.put_byte(8'ha4);
      begin
        #400 @(posedge mclk);
        stop_req <= 1'b1;
        repeat (8) @(posedge mclk);
        chk(stop_ack === 1'b1, "ungated ack");
      end
    join
    stop_req <= 1'b0;
    repeat (8) @(posedge mclk);
    pm.start_c();
    pm.put_byte(8'ha4);
    pm.stop_c();
    print_verdict;
  end
endmodule
